//--- supply_monitor_pkg.sv
/*
   Constants, register map and types of the supply monitor flag block.
   Assumes a low-speed oscillator of LOW_SPEED_INTERNAL_OSC_KHZ and 8-bit registers.
*/
package supply_monitor_pkg;

   // ==========================================================
   // register map
   localparam logic [7:0] ADDR_PWR_CTRL  = 8'h87;
   localparam logic [7:0] ADDR_DET_CTRL0 = 8'hA3;
   localparam logic [7:0] ADDR_DET_CTRL1 = 8'hAB;
   localparam logic [7:0] ADDR_UNLOCK    = 8'hC0;
   localparam logic [7:0] UNLOCK_KEY1    = 8'hAA;
   localparam logic [7:0] UNLOCK_KEY2    = 8'h55;

   // ==========================================================
   // field positions
   localparam int PC_POF_BIT   = 4;
   localparam int D0_EN_BIT    = 7;
   localparam int D0_LVL_LSB   = 4;
   localparam int D0_EVT_BIT   = 3;
   localparam int D0_RSEL_BIT  = 2;
   localparam int D0_RFLG_BIT  = 1;
   localparam int D0_STAT_BIT  = 0;
   localparam int D1_LP_LSB    = 1;
   localparam int D1_FLT_BIT   = 0;
   localparam int CFG_EN_BIT   = 7;
   localparam int CFG_LVL_LSB  = 4;
   localparam int CFG_RSEL_BIT = 2;
   localparam int LVL_W        = 2;

   // ==========================================================
   // encodings
   localparam logic [1:0] LVL_2V2 = 2'h3;
   localparam logic [1:0] LVL_2V7 = 2'h2;
   localparam logic [1:0] LVL_3V7 = 2'h1;
   localparam logic [1:0] LVL_4V4 = 2'h0;
   localparam logic [1:0] LP_CONT = 2'h0;
   localparam logic [1:0] LP_MODE1 = 2'h1;
   localparam logic [1:0] LP_MODE2 = 2'h2;
   localparam logic [1:0] LP_MODE3 = 2'h3;

   // ==========================================================
   // values after reset
   localparam logic       FLT_EN_RST  = 1'h1;
   localparam logic [1:0] LP_MODE_RST = 2'h0;

   // ==========================================================
   // timing
   localparam int LOW_SPEED_INTERNAL_OSC_KHZ       = 10;
   localparam int LP1_US         = 1600;
   localparam int LP2_US         = 6400;
   localparam int LP3_US         = 25600;
   localparam int LP1_TICKS      = LP1_US * LOW_SPEED_INTERNAL_OSC_KHZ / 1000;
   localparam int LP2_TICKS      = LP2_US * LOW_SPEED_INTERNAL_OSC_KHZ / 1000;
   localparam int LP3_TICKS      = LP3_US * LOW_SPEED_INTERNAL_OSC_KHZ / 1000;
   localparam int BLANK_TICKS    = 3;
   localparam int FLT_FAST_CYC   = 32;
   localparam int FLT_SLOW_TICKS = 2;
   localparam int TA_WINDOW_CYC  = 4;
   localparam logic [1:0] BLANK_LOAD     = 2'(BLANK_TICKS);
   localparam logic [5:0] FLT_FAST_LAST  = 6'(FLT_FAST_CYC - 1);
   localparam logic [5:0] FLT_SLOW_LAST  = 6'(FLT_SLOW_TICKS - 1);
   localparam logic [2:0] TA_WINDOW_LOAD = 3'(TA_WINDOW_CYC);

   // ==========================================================
   // types
   typedef enum logic [1:0] {TA_LOCKED, TA_HALF, TA_OPEN} ta_state_t;

   // last count of a sensing period, in low-speed ticks
   function automatic logic [8:0] periodLast(input logic [1:0] mode);
      case (mode)
         LP_MODE1: periodLast = 9'(LP1_TICKS - 1);
         LP_MODE2: periodLast = 9'(LP2_TICKS - 1);
         default:  periodLast = 9'(LP3_TICKS - 1);
      endcase
   endfunction : periodLast

endpackage : supply_monitor_pkg

//--- supply_monitor_flags.sv
/*
   Digital side of the supply monitor: power-on flag, brownout event,
   level and reset flags, enable blanking, periodic low-power sensing,
   noise filter and the register port with the timed unlock.
   Power control carries the power-on flag in bit 4 and nothing else.
   Detector control 0 carries the enable, a 3-bit level field that
   reads back whole although only its low two bits reach the
   reference, the event flag, reset select, reset flag and the
   read-only level status. Detector control 1 carries the low-power
   sense mode and the filter enable. Each write to either detector
   control needs its own two-key unlock; a write outside the window
   is dropped without a trace.
   brownoutReset is a level, not a pulse: it stands while the filtered
   supply stays low with reset select set; the system turns it into an
   srst with porRst low, so the reset flag survives that reset.
   Assumes compLow, lircTick and all bus signals are synchronous to clk;
   lircTick is a one-cycle pulse per low-speed oscillator period; porRst
   is high together with srst during a power-on reset.
*/
// Functional notes
// - power-on reset sets the power-on flag
// - power-on flag survives other resets, clearable
// - drop with reset select 0 sets event
// - clearing while low does not re-set
// - supply resuming also sets event flag
// - read-only level status bit
// - drop with reset select 1 forces reset
// - reset flag set by brownout, kept, clearable
// - control 0 writes need the unlock sequence
// - ignore comparator 2~3 slow ticks after enable
// - periodic sensing at 1.6/6.4/25.6 ms
// - filter on by default, 0 disables
// - level codes 11/10/01/00 pick trip level
// - runtime level field overrides boot choice
// - boot enable bit switches detector on/off
// - boot reset select bit enables brownout reset
// - every reset reloads enable, level, reset select
// - filter 32 sys clocks or 2 slow ticks
// - mode 00 continuous, others periodic
// - level status reads 0 when disabled
`timescale 1ns/1ns

module supply_monitor_flags (
   input  wire  logic       clk,
   input  wire  logic       srst,
   input  wire  logic       ce,
   input  wire  logic       porRst,
   input  wire  logic [7:0] bootCfg,
   input  wire  logic       compLow,
   input  wire  logic       lircTick,
   input  wire  logic       sysOnFast,
   input  wire  logic [7:0] regAddr,
   input  wire  logic [7:0] regWdata,
   input  wire  logic       regWr,
   input  wire  logic       regRd,
   output logic [7:0]       regRdata,
   output logic             brownoutIrq,
   output logic             brownoutReset,
   output logic             compEnable,
   output logic [supply_monitor_pkg::LVL_W-1:0] tripLevel
);
   import supply_monitor_pkg::*;

   // ==========================================================
   // state
   typedef struct packed {
      ta_state_t  taSt;
      logic [2:0] taCnt;
      logic       detEn;
      logic [2:0] lvlSel;
      logic       evtFlag;
      logic       rstSel;
      logic       rstFlag;
      logic       porFlag;
      logic [1:0] lpMode;
      logic       fltEn;
      logic       compOn;
      logic [1:0] blankCnt;
      logic [8:0] perCnt;
      logic [5:0] fltCnt;
      logic       lvl;
      logic       rstReq;
      logic       prevEn;
      logic [7:0] rdata;
   } state_t;

   state_t s_q;
   state_t s_d;

   logic       unlockWr;
   logic       protWr;
   logic       wrOk;
   logic       lowPower;
   logic       fastFlt;
   logic       valid;
   logic       enRise;
   logic       lvlUpd;
   logic       keepPor;
   logic       keepRst;
   logic [6:0] step;

   // ==========================================================
   // one filter step on a differing sample: {take, next count}
   function automatic logic [6:0] fltStep(
      input logic [5:0] cnt,
      input logic [5:0] last
   );
      if (cnt >= last) begin
         fltStep = 7'h40;
      end else begin
         fltStep = {1'h0, cnt + 6'h1};
      end
   endfunction : fltStep

   // ==========================================================
   // register images as software reads them
   function automatic logic [7:0] regImage(
      input state_t     s,
      input logic [7:0] addr
   );
      regImage = 8'h0;
      case (addr)
         ADDR_PWR_CTRL: begin
            regImage[PC_POF_BIT] = s.porFlag;
         end
         ADDR_DET_CTRL0: begin
            regImage[D0_EN_BIT]       = s.detEn;
            regImage[D0_LVL_LSB +: 3] = s.lvlSel;
            regImage[D0_EVT_BIT]      = s.evtFlag;
            regImage[D0_RSEL_BIT]     = s.rstSel;
            regImage[D0_RFLG_BIT]     = s.rstFlag;
            // status is never written by software
            regImage[D0_STAT_BIT] = s.detEn && s.lvl;
         end
         ADDR_DET_CTRL1: begin
            regImage[D1_LP_LSB +: 2] = s.lpMode;
            regImage[D1_FLT_BIT]     = s.fltEn;
         end
         default: begin
            regImage = 8'h0;
         end
      endcase
   endfunction : regImage

   // ==========================================================
   // next state
   always_comb begin
      s_d = s_q;
      keepPor = 1'h0;
      keepRst = 1'h0;
      step    = 7'h0;

      unlockWr = regWr && (regAddr == ADDR_UNLOCK);
      protWr   = regWr && ((regAddr == ADDR_DET_CTRL0) ||
                           (regAddr == ADDR_DET_CTRL1));
      wrOk     = protWr && (s_q.taSt == TA_OPEN);

      lowPower = (s_q.lpMode != LP_CONT);
      fastFlt  = sysOnFast && !lowPower;
      // blanking hides the comparator while it powers up
      valid    = s_q.compOn && (s_q.blankCnt == 2'h0);
      enRise   = s_q.detEn && !s_q.prevEn;

      // =======================================================
      // timed unlock: key1, key2, then one protected write
      case (s_q.taSt)
         TA_LOCKED: begin
            if (unlockWr && (regWdata == UNLOCK_KEY1)) begin
               s_d.taSt = TA_HALF;
            end
         end
         TA_HALF: begin
            // any other write in between breaks the sequence
            if (unlockWr && (regWdata == UNLOCK_KEY2)) begin
               s_d.taSt  = TA_OPEN;
               s_d.taCnt = TA_WINDOW_LOAD;
            end else if (regWr) begin
               s_d.taSt = TA_LOCKED;
            end
         end
         TA_OPEN: begin
            // window closes on the write or after a few cycles
            if (protWr || (s_q.taCnt == 3'h0)) begin
               s_d.taSt = TA_LOCKED;
            end else begin
               s_d.taCnt = s_q.taCnt - 3'h1;
            end
         end
         default: begin
            s_d.taSt = TA_LOCKED;
         end
      endcase

      // =======================================================
      // software writes
      if (regWr && (regAddr == ADDR_PWR_CTRL)) begin
         s_d.porFlag = regWdata[PC_POF_BIT];
      end
      if (wrOk && (regAddr == ADDR_DET_CTRL0)) begin
         s_d.detEn   = regWdata[D0_EN_BIT];
         s_d.lvlSel  = regWdata[D0_LVL_LSB +: 3];
         s_d.evtFlag = regWdata[D0_EVT_BIT];
         s_d.rstSel  = regWdata[D0_RSEL_BIT];
         s_d.rstFlag = regWdata[D0_RFLG_BIT];
      end
      if (wrOk && (regAddr == ADDR_DET_CTRL1)) begin
         s_d.lpMode = regWdata[D1_LP_LSB +: 2];
         s_d.fltEn  = regWdata[D1_FLT_BIT];
      end

      // =======================================================
      // comparator power and blanking
      s_d.prevEn = s_q.detEn;
      if (!s_q.detEn) begin
         s_d.compOn   = 1'h0;
         s_d.blankCnt = BLANK_LOAD;
         s_d.perCnt   = 9'h0;
         s_d.fltCnt   = 6'h0;
         s_d.lvl      = 1'h0;
      end else begin
         if (s_q.compOn && (s_q.blankCnt != 2'h0) && lircTick) begin
            s_d.blankCnt = s_q.blankCnt - 2'h1;
         end

         // ====================================================
         // noise filter, output ignored until valid
         if (valid) begin
            if (compLow == s_q.lvl) begin
               s_d.fltCnt = 6'h0;
               // settled sample taken: a periodic window may end
               if (lowPower) begin
                  s_d.compOn = 1'h0;
               end
            end else if (!s_q.fltEn) begin
               s_d.lvl = compLow;
            end else if (fastFlt || lircTick) begin
               // fast filter counts clocks, slow one counts ticks
               step = fltStep(s_q.fltCnt,
                              fastFlt ? FLT_FAST_LAST : FLT_SLOW_LAST);
               s_d.fltCnt = step[5:0];
               if (step[6]) begin
                  s_d.lvl = compLow;
               end
            end
         end

         // ====================================================
         // continuous or periodic sensing
         if (!lowPower) begin
            s_d.perCnt = 9'h0;
            s_d.compOn = 1'h1;
            if (!s_q.compOn) begin
               s_d.blankCnt = BLANK_LOAD;
            end
         end else if (lircTick) begin
            if (s_q.perCnt >= periodLast(s_q.lpMode)) begin
               // period wrap wins over an unfinished window
               s_d.perCnt   = 9'h0;
               s_d.compOn   = 1'h1;
               s_d.blankCnt = BLANK_LOAD;
            end else begin
               s_d.perCnt = s_q.perCnt + 9'h1;
            end
         end

         // a fresh enable restarts blanking, even mid-period
         if (enRise) begin
            s_d.compOn   = 1'h1;
            s_d.blankCnt = BLANK_LOAD;
            s_d.perCnt   = 9'h0;
            s_d.fltCnt   = 6'h0;
         end
      end

      // =======================================================
      // events: edges only, so a clear while low sticks
      lvlUpd = s_q.detEn && valid && (s_d.lvl != s_q.lvl);
      if (lvlUpd) begin
         if (s_d.lvl) begin
            if (!s_q.rstSel) begin
               s_d.evtFlag = 1'h1;
            end
         end else begin
            s_d.evtFlag = 1'h1;
         end
      end

      // reset request held while the supply stays low
      s_d.rstReq = s_q.detEn && s_q.rstSel && s_q.lvl;
      if (s_d.rstReq && !s_q.rstReq) begin
         s_d.rstFlag = 1'h1;
      end

      // =======================================================
      // read data, valid in the cycle after the strobe only
      s_d.rdata = 8'h0;
      if (regRd) begin
         s_d.rdata = regImage(s_q, regAddr);
      end

      // =======================================================
      // reset: two flags survive all but power-on
      if (srst) begin
         // flags taken after this cycle's writes, so none is lost
         keepPor = s_d.porFlag;
         keepRst = s_d.rstFlag;
         s_d = '0;
         s_d.taSt     = TA_LOCKED;
         s_d.detEn    = bootCfg[CFG_EN_BIT];
         s_d.lvlSel   = bootCfg[CFG_LVL_LSB +: 3];
         s_d.rstSel   = bootCfg[CFG_RSEL_BIT];
         s_d.lpMode   = LP_MODE_RST;
         s_d.fltEn    = FLT_EN_RST;
         s_d.blankCnt = BLANK_LOAD;
         s_d.porFlag  = keepPor;
         s_d.rstFlag  = keepRst;
         if (porRst) begin
            s_d.porFlag = 1'h1;
            s_d.rstFlag = 1'h0;
         end
      end
   end

   // ==========================================================
   // registers; reset is not gated by the clock enable
   always_ff @(posedge clk) begin
      if (srst || ce) begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // outputs
   // all straight from the state register
   assign regRdata      = s_q.rdata;
   assign brownoutIrq   = s_q.evtFlag;
   assign brownoutReset = s_q.rstReq;
   assign compEnable    = s_q.compOn;
   // level code feeds the analog reference directly
   assign tripLevel     = s_q.lvlSel[LVL_W-1:0];

endmodule : supply_monitor_flags

//--- supply_monitor_flags_properties.sv
/*
   Port checker of the supply monitor flag block.
   Assumes a bind into supply_monitor_flags; while ce is low the
   watched state holds, so all but rdata_idle_a, flag_mirror_a and status_off_a stay true.
*/
`timescale 1ns/1ns

module supply_monitor_flags_checker
   import supply_monitor_pkg::*;
(
   input wire logic             clk,
   input wire logic             srst,
   input wire logic             ce,
   input wire logic             porRst,
   input wire logic [7:0]       bootCfg,
   input wire logic             compLow,
   input wire logic             lircTick,
   input wire logic             sysOnFast,
   input wire logic [7:0]       regAddr,
   input wire logic [7:0]       regWdata,
   input wire logic             regWr,
   input wire logic             regRd,
   input wire logic [7:0]       regRdata,
   input wire logic             brownoutIrq,
   input wire logic             brownoutReset,
   input wire logic             compEnable,
   input wire logic [LVL_W-1:0] tripLevel
);
   // ======================================================
   // cycles since last unlock write, saturates so reset is locked
   logic [2:0] keyAge_q;
   logic [2:0] keyAge_d;

   always_comb begin
      keyAge_d = keyAge_q;
      if (keyAge_q != 3'h7) keyAge_d = keyAge_q + 3'h1;
      if (regWr && regAddr == ADDR_UNLOCK) keyAge_d = 3'h0;
   end

   always_ff @(posedge clk) begin
      keyAge_q <= srst ? 3'h7 : keyAge_d;
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   // ======================================================
   // assertions
   rdata_idle_a: assert property (!regRd |=> regRdata == 8'h00)
      else $error("read data not zero outside a read");
   flag_mirror_a: assert property (
      regRd && regAddr == ADDR_DET_CTRL0
      |=> regRdata[D0_EVT_BIT] == $past(brownoutIrq))
      else $error("event bit differs from interrupt output");
   status_off_a: assert property (
      regRd && regAddr == ADDR_DET_CTRL0
      |=> regRdata[D0_EN_BIT] || !regRdata[D0_STAT_BIT])
      else $error("level status set while detector off");
   level_hold_a: assert property (!regWr |=> $stable(tripLevel))
      else $error("trip level moved without a write");
   boot_load_a: assert property (
      $fell(srst) |-> tripLevel == $past(bootCfg[CFG_LVL_LSB +: LVL_W]))
      else $error("trip level not loaded from boot word");
   locked_write_a: assert property (
      regWr && regAddr == ADDR_DET_CTRL0 && keyAge_q > 3'h6
      |=> $stable(tripLevel))
      else $error("protected write took effect while locked");
   blank_hold_a: assert property (
      $rose(compEnable) && !brownoutReset |=> !brownoutReset [*2])
      else $error("comparator heard during blanking");
   event_cause_a: assert property (
      $rose(brownoutIrq) |-> $past(compEnable) || $past(regWr))
      else $error("event flag rose with comparator off");

endmodule : supply_monitor_flags_checker

//--- comparator_model.sv
/*
   Behavioural supply comparator facing the block.
   Assumes supplyLow is set by the bench at rising edges.
*/
`timescale 1ns/1ns

module comparator_model (
   input  wire logic clk,
   input  wire logic compEnable,
   input  wire logic supplyLow,
   output logic      compLow
);
   // unpowered output toggles so no stale level looks valid
   initial compLow = 1'b0;
   always @(posedge clk) begin
      compLow <= compEnable ? supplyLow : ~compLow;
   end
endmodule : comparator_model

//--- tb.sv
/*
   Self-checking bench of the supply monitor flag block.
   Assumes the package, comparator model and checker compiled first.
*/
`timescale 1ns/1ns

module tb;
   import supply_monitor_pkg::*;

   localparam int TICK_CYC = 4;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic        porRst = 1'b1;
   logic [7:0]  bootCfg = 8'hA0;
   logic        compLow;
   logic        lircTick = 1'b0;
   logic        sysOnFast = 1'b0;
   logic [7:0]  regAddr = 8'h00;
   logic [7:0]  regWdata = 8'h00;
   logic        regWr = 1'b0;
   logic        regRd = 1'b0;
   logic        ce = 1'b1;
   logic [7:0]  regRdata;
   logic        brownoutIrq;
   logic        brownoutReset;
   logic        compEnable;
   logic [1:0]  tripLevel;
   logic        supplyLow = 1'b0;
   logic        rdPend = 1'b0;
   logic        enPrev = 1'b0;
   logic [1:0]  tickCnt = 2'h0;
   logic [15:0] sinceRise = 16'h0000;
   logic [15:0] gap = 16'h0000;
   logic [7:0]  expQ[$];
   logic [31:0] seed = 32'h36D1;
   int          lpTicks[3] = '{LP1_TICKS, LP2_TICKS, LP3_TICKS};
   int          errors = 0;
   int          checks_done = 0;

   supply_monitor_flags i_supply_monitor_flags (
      .clk(clk), .srst(srst), .ce(ce), .porRst(porRst),
      .bootCfg(bootCfg), .compLow(compLow), .lircTick(lircTick),
      .sysOnFast(sysOnFast), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .brownoutIrq(brownoutIrq), .brownoutReset(brownoutReset),
      .compEnable(compEnable), .tripLevel(tripLevel));
   comparator_model i_comparator_model (.clk(clk),
      .compEnable(compEnable), .supplyLow(supplyLow), .compLow(compLow));

   // ======================================================
   // clock, slow tick, period meter, read monitor
   initial forever #25 clk = ~clk;
   always @(posedge clk) begin
      tickCnt  <= tickCnt + 2'h1;
      lircTick <= tickCnt == 2'h3;
      rdPend   <= regRd;
      enPrev   <= compEnable;
      sinceRise <= sinceRise + 16'h0001;
      if (compEnable && !enPrev) begin
         gap       <= sinceRise;
         sinceRise <= 16'h0001;
      end
   end
   always @(negedge clk) begin
      if (rdPend) check({8'h00, regRdata}, {8'h00, expQ.pop_front()});
   end

   // ======================================================
   // helpers
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      xorshift = x ^ (x << 5);
   endfunction : xorshift

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr  <= a;
      regWdata <= d;
      regWr    <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask : wr

   // protected registers need both keys before each write
   task automatic prot(input logic [7:0] a, input logic [7:0] d);
      wr(ADDR_UNLOCK, UNLOCK_KEY1);
      wr(ADDR_UNLOCK, UNLOCK_KEY2);
      wr(a, d);
   endtask : prot

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      regAddr <= a;
      regRd   <= 1'b1;
      expQ.push_back(e);
      @(posedge clk);
      regRd <= 1'b0;
   endtask : rd

   task automatic rst(input logic por);
      @(posedge clk);
      srst   <= 1'b1;
      porRst <= por;
      repeat (2) @(posedge clk);
      srst   <= 1'b0;
      porRst <= 1'b0;
   endtask : rst

   task automatic waitc(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : waitc

   task automatic give_verdict;
      $display("errors %0d checks_done %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : give_verdict

   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      give_verdict();
   end

   // ======================================================
   // main sequence
   initial begin
      seed = xorshift(seed);
      sysOnFast <= seed[0];
      repeat (2) @(posedge clk);
      srst   <= 1'b0;
      porRst <= 1'b0;
      rd(ADDR_PWR_CTRL, 8'h10);
      rd(ADDR_DET_CTRL0, 8'hA0);
      rd(ADDR_DET_CTRL1, 8'h01);
      rd(8'h00, 8'h00);
      rst(1'b0);
      rd(ADDR_PWR_CTRL, 8'h10);
      seed = xorshift(seed);
      wr(ADDR_PWR_CTRL, seed[7:0]);
      rd(ADDR_PWR_CTRL, seed[7:0] & 8'h10);
      wr(ADDR_DET_CTRL0, 8'h00);
      rd(ADDR_DET_CTRL0, 8'hA0);
      prot(ADDR_DET_CTRL1, 8'h00);
      rd(ADDR_DET_CTRL1, 8'h00);
      // clock enable low: the unlock and the write are both lost
      @(posedge clk) ce <= 1'b0;
      prot(ADDR_DET_CTRL1, 8'h07);
      @(posedge clk) ce <= 1'b1;
      rd(ADDR_DET_CTRL1, 8'h00);
      @(posedge clk) supplyLow <= 1'b1;
      waitc(40);
      check({15'h0000, brownoutIrq}, 16'h0001);
      rd(ADDR_DET_CTRL0, 8'hA9);
      prot(ADDR_DET_CTRL0, 8'hA0);
      waitc(40);
      rd(ADDR_DET_CTRL0, 8'hA1);
      @(posedge clk) supplyLow <= 1'b0;
      waitc(40);
      rd(ADDR_DET_CTRL0, 8'hA8);
      for (int i = 0; i < 4; i++) begin
         prot(ADDR_DET_CTRL0, 8'h80 | 8'(i << 4));
         waitc(1);
         check({14'h0000, tripLevel}, 16'(i));
      end
      prot(ADDR_DET_CTRL0, 8'hB4);
      @(posedge clk) supplyLow <= 1'b1;
      waitc(40);
      check({14'h0000, brownoutReset, brownoutIrq}, 16'h0002);
      rd(ADDR_DET_CTRL0, 8'hB7);
      @(posedge clk) supplyLow <= 1'b0;
      rst(1'b0);
      rd(ADDR_DET_CTRL0, 8'hA2);
      prot(ADDR_DET_CTRL0, 8'h20);
      @(posedge clk) supplyLow <= 1'b1;
      waitc(40);
      rd(ADDR_DET_CTRL0, 8'h20);
      prot(ADDR_DET_CTRL0, 8'hA0);
      waitc(60);
      check({15'h0000, brownoutIrq}, 16'h0001);
      @(posedge clk) bootCfg <= 8'h34;
      rst(1'b1);
      rd(ADDR_DET_CTRL0, 8'h34);
      rd(ADDR_PWR_CTRL, 8'h10);
      waitc(20);
      check({15'h0000, compEnable}, 16'h0000);
      @(posedge clk) bootCfg <= 8'hA0;
      supplyLow <= 1'b0;
      rst(1'b0);
      waitc(20);
      check({15'h0000, compEnable}, 16'h0001);
      // long waits: first gap after a mode switch is partial
      for (int m = 1; m < 4; m++) begin
         prot(ADDR_DET_CTRL1, 8'(m << 1));
         waitc(3 * lpTicks[m - 1] * TICK_CYC);
         check(gap, 16'(lpTicks[m - 1] * TICK_CYC));
      end
      give_verdict();
   end
endmodule : tb

bind supply_monitor_flags supply_monitor_flags_checker
   i_supply_monitor_flags_checker (
   .clk(clk), .srst(srst), .ce(ce), .porRst(porRst), .bootCfg(bootCfg),
   .compLow(compLow), .lircTick(lircTick), .sysOnFast(sysOnFast),
   .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
   .regRdata(regRdata), .brownoutIrq(brownoutIrq),
   .brownoutReset(brownoutReset), .compEnable(compEnable),
   .tripLevel(tripLevel));
